/* File: verilog/sqk_defs.vh */
`ifndef SQK_DEFS_VH
`define SQK_DEFS_VH
// Chip selects, field widths and FIFO size
`define SQK_NCS          4
`define SQK_CS_W         2
`define SQK_DIV_W        8
`define SQK_DATA_W       8
`define SQK_FIFO_DEPTH   8
`define SQK_FIFO_AW      3
// Reset values and last bit count
`define SQK_DIV_RESET    8'h01
`define SQK_DATA_RESET   8'h00
`define SQK_BITCNT_LAST  3'h7
`endif

/* File: verilog/sqk_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module sqk_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    input  wire             flush,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sqk_fifo
`default_nettype wire

/* File: verilog/sqk_spi.v */
`timescale 1ns/1ps
`default_nettype none
`include "sqk_defs.vh"
module sqk_spi (
    // Clock and reset
    input  wire                  clock,
    input  wire                  rst_n,
    // Control register bits
    input  wire                  enable_cmd,
    input  wire                  disable_cmd,
    input  wire                  soft_reset_bit,
    input  wire                  master_mode,
    input  wire [`SQK_CS_W-1:0]  cs_select,
    // Chip select config, flattened per select
    input  wire [`SQK_NCS*`SQK_DIV_W-1:0] baud_divider_field,
    input  wire [`SQK_NCS-1:0]   clock_polarity,
    input  wire [`SQK_NCS-1:0]   phase_capture_select,
    input  wire [`SQK_NCS-1:0]   cs_in_use,
    // Transmit data register write (CPU or DMA)
    input  wire                  transmit_data_reg_wr,
    input  wire [`SQK_DATA_W-1:0] transmit_data_reg,
    output reg                   tx_wr_ready,
    // Received data read
    input  wire                  rx_read,
    output reg  [`SQK_DATA_W-1:0] rx_data,
    // Status register bits
    output reg                   spi_enabled,
    output reg                   tx_holding_empty_flag,
    output reg                   rx_full_flag,
    output reg                   busy,
    // Serial pins
    output reg                   sck,
    output reg                   mosi,
    input  wire                  miso,
    output reg  [`SQK_NCS-1:0]   cs_n
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_LOW   = 3'b010;
    localparam ST_HIGH  = 3'b100;

    reg  [2:0]              state;
    reg  [`SQK_DIV_W-1:0]   div_cnt;
    reg  [2:0]              bit_cnt;
    reg  [`SQK_DATA_W-1:0]  shreg;
    reg                     glitch_pend;
    reg                     last_div_one;
    wire                    f_ready;
    wire                    f_valid;
    wire [`SQK_DATA_W-1:0]  f_data;
    wire                    f_pop;

    function [`SQK_DIV_W-1:0] div_of;
        input [`SQK_CS_W-1:0] idx;
        begin
            div_of = baud_divider_field[idx*`SQK_DIV_W +: `SQK_DIV_W];
        end
    endfunction

    function div_is_one;
        input [`SQK_CS_W-1:0] idx;
        begin
            div_is_one = (div_of(idx) == `SQK_DIV_RESET);
        end
    endfunction

    // Mixed dividers across selects in use, for the extra-pulse quirk
    reg any_one;
    reg any_other;
    integer i;
    always @* begin
        any_one   = 1'b0;
        any_other = 1'b0;
        for (i = 0; i < `SQK_NCS; i = i + 1) begin
            if (cs_in_use[i]) begin
                if (div_is_one(i[`SQK_CS_W-1:0])) begin
                    any_one = 1'b1;
                end else begin
                    any_other = 1'b1;
                end
            end
        end
    end
    wire mixed_quirk = any_one && any_other
        && clock_polarity[cs_select] && !phase_capture_select[cs_select];

    // Writes pass only while enabled; disabled writes still handshake
    wire wr_take = transmit_data_reg_wr && spi_enabled && f_ready;
    assign f_pop = (state == ST_IDLE) && f_valid && spi_enabled;

    sqk_fifo #(
        .WIDTH (`SQK_DATA_W),
        .DEPTH (`SQK_FIFO_DEPTH),
        .AW    (`SQK_FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .flush     (soft_reset_bit),
        .in_data   (transmit_data_reg),
        .in_valid  (wr_take),
        .in_ready  (f_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_enabled           <= 1'b0;
            tx_holding_empty_flag <= 1'b1;
            tx_wr_ready           <= 1'b0;
            rx_full_flag          <= 1'b0;
            rx_data               <= `SQK_DATA_RESET;
            busy                  <= 1'b0;
            state                 <= ST_IDLE;
            div_cnt               <= {`SQK_DIV_W{1'b0}};
            bit_cnt               <= 3'h0;
            shreg                 <= `SQK_DATA_RESET;
            glitch_pend           <= 1'b0;
            last_div_one          <= 1'b0;
            sck                   <= 1'b0;
            mosi                  <= 1'b0;
            cs_n                  <= {`SQK_NCS{1'b1}};
        end else if (soft_reset_bit) begin
            spi_enabled           <= 1'b0;
            tx_holding_empty_flag <= 1'b1;
            tx_wr_ready           <= 1'b0;
            rx_full_flag          <= 1'b0;
            rx_data               <= `SQK_DATA_RESET;
            busy                  <= 1'b0;
            state                 <= ST_IDLE;
            div_cnt               <= {`SQK_DIV_W{1'b0}};
            bit_cnt               <= 3'h0;
            glitch_pend           <= 1'b0;
            sck                   <= clock_polarity[cs_select];
            mosi                  <= 1'b0;
            cs_n                  <= {`SQK_NCS{1'b1}};
        end else begin
            if (enable_cmd) begin
                spi_enabled <= 1'b1;
            end else if (disable_cmd && master_mode) begin
                spi_enabled <= 1'b0;
            end
            // Disabled: DMA still sees ready, so its words vanish
            tx_wr_ready <= f_ready || !spi_enabled;
            // Flag follows the queue only while enabled
            if (wr_take) begin
                tx_holding_empty_flag <= 1'b0;
            end else if (spi_enabled && !f_valid) begin
                tx_holding_empty_flag <= 1'b1;
            end
            if (rx_read) begin
                rx_full_flag <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    sck  <= clock_polarity[cs_select];
                    busy <= 1'b0;
                    if (f_pop && master_mode) begin
                        shreg        <= f_data;
                        mosi         <= f_data[`SQK_DATA_W-1];
                        bit_cnt      <= 3'h0;
                        div_cnt      <= div_of(cs_select);
                        cs_n         <= ~({{(`SQK_NCS-1){1'b0}}, 1'b1}
                                          << cs_select);
                        busy         <= 1'b1;
                        // Divider switch to or from 1 leaks one pulse
                        glitch_pend  <= mixed_quirk
                            && (last_div_one != div_is_one(cs_select));
                        last_div_one <= div_is_one(cs_select);
                        state        <= ST_LOW;
                    end else begin
                        cs_n <= {`SQK_NCS{1'b1}};
                    end
                end
                ST_LOW: begin
                    if (div_cnt > 8'h01) begin
                        div_cnt <= div_cnt - 8'h01;
                    end else begin
                        div_cnt <= div_of(cs_select);
                        sck     <= ~sck;
                        if (glitch_pend) begin
                            glitch_pend <= 1'b0;
                        end else begin
                            shreg <= {shreg[`SQK_DATA_W-2:0], miso};
                            state <= ST_HIGH;
                        end
                    end
                end
                ST_HIGH: begin
                    if (div_cnt > 8'h01) begin
                        div_cnt <= div_cnt - 8'h01;
                    end else begin
                        div_cnt <= div_of(cs_select);
                        sck     <= ~sck;
                        mosi    <= shreg[`SQK_DATA_W-1];
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `SQK_BITCNT_LAST) begin
                            rx_data      <= shreg;
                            rx_full_flag <= 1'b1;
                            state        <= ST_IDLE;
                        end else begin
                            state <= ST_LOW;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // sqk_spi
`default_nettype wire

/* File: sim/sqk_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module sqk_slave (
    // Clock and serial pins
    input  wire logic       clock,
    input  wire logic [3:0] cs_n,
    input  wire logic       mosi,
    output var  logic       miso
);
    logic wander = 1'b0;
    // Echo slave; unselected line wanders so stale bits never match
    always_ff @(posedge clock) wander <= ~wander;
    always_comb miso = (cs_n != 4'hf) ? mosi : wander;
endmodule // sqk_slave
`default_nettype wire

/* File: sim/sqk_spi_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sqk_spi_checker (
    // Clock, reset, controls
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       enable_cmd,
    input wire logic       disable_cmd,
    input wire logic       soft_reset_bit,
    input wire logic       master_mode,
    input wire logic [1:0] cs_select,
    input wire logic [3:0] phase_capture_select,
    input wire logic       transmit_data_reg_wr,
    // Status and pins
    input wire logic       tx_wr_ready,
    input wire logic       spi_enabled,
    input wire logic       tx_holding_empty_flag,
    input wire logic       busy,
    input wire logic       sck,
    input wire logic [3:0] cs_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [4:0] cnt;
    logic       sck_q;
    // Select is high under reset, so the count starts clean
    always_ff @(posedge clock) begin
        sck_q <= sck;
        cnt   <= cs_n[cs_select] ? 5'h00 : cnt + {4'h0, sck != sck_q};
    end
    property p_lost; !spi_enabled && !busy && !enable_cmd |=> !busy;
    endproperty
    a_lost: assert property (p_lost) else $error("Frame while off");
    property p_acc; spi_enabled && transmit_data_reg_wr && tx_wr_ready
        && !soft_reset_bit |=> !tx_holding_empty_flag; endproperty
    a_acc: assert property (p_acc) else $error("Flag kept");
    property p_flag; !spi_enabled && !enable_cmd && !soft_reset_bit
        |=> $stable(tx_holding_empty_flag); endproperty
    a_flag: assert property (p_flag) else $error("Flag moved");
    property p_rdy; !spi_enabled && !soft_reset_bit
        |=> tx_wr_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("Write held off");
    property p_slv; !master_mode && spi_enabled && !soft_reset_bit
        |=> spi_enabled; endproperty
    a_slv: assert property (p_slv) else $error("Slave stopped");
    property p_off; master_mode && disable_cmd && !enable_cmd
        && !soft_reset_bit |=> !spi_enabled; endproperty
    a_off: assert property (p_off) else $error("Disable lost");
    property p_srst; soft_reset_bit |=> !spi_enabled && !busy
        && tx_holding_empty_flag && cs_n == 4'hf; endproperty
    a_srst: assert property (p_srst) else $error("Reset missed");
    property p_edge; $rose(cs_n[cs_select]) && phase_capture_select[cs_select]
        && !$past(soft_reset_bit) |-> cnt == 5'h10; endproperty
    a_edge: assert property (p_edge) else $error("Edge count");
    c_frame: cover property ($fell(busy));
    c_drop: cover property (!spi_enabled && transmit_data_reg_wr);
    c_slave: cover property (!master_mode && disable_cmd);
endmodule // sqk_spi_checker
bind sqk_spi sqk_spi_checker chk (.clock, .rst_n, .enable_cmd, .disable_cmd,
    .soft_reset_bit, .master_mode, .cs_select, .phase_capture_select,
    .transmit_data_reg_wr, .tx_wr_ready, .spi_enabled, .tx_holding_empty_flag,
    .busy, .sck, .cs_n);
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module tb_top;
    logic clock = 1'b0, rst_n = 1'b0, enable_cmd = 1'b0, disable_cmd = 1'b0;
    logic soft_reset_bit = 1'b0, master_mode = 1'b1, rx_read = 1'b0;
    logic transmit_data_reg_wr = 1'b0;
    logic [1:0] cs_select = 2'h0;
    logic [31:0] baud_divider_field = 32'h04040404;
    logic [3:0] clock_polarity = 4'h0, phase_capture_select = 4'hf;
    logic [3:0] cs_in_use = 4'h1, cs_n;
    logic [7:0] transmit_data_reg = 8'h00, rx_data;
    logic tx_wr_ready, spi_enabled, tx_holding_empty_flag;
    logic rx_full_flag, busy, sck, mosi, miso;
    int bad_count = 0, num_checks = 0, edges = 0;
    sqk_spi uut (.clock, .rst_n, .enable_cmd, .disable_cmd, .soft_reset_bit,
        .master_mode, .cs_select, .baud_divider_field, .clock_polarity,
        .phase_capture_select, .cs_in_use, .transmit_data_reg_wr,
        .transmit_data_reg, .tx_wr_ready, .rx_read, .rx_data, .spi_enabled,
        .tx_holding_empty_flag, .rx_full_flag, .busy, .sck, .mosi, .miso,
        .cs_n);
    sqk_slave peer (.clock, .cs_n, .mosi, .miso);
    initial forever #2 clock = ~clock;
    always @(sck) edges++;
    task automatic tick(int k); repeat (k) @(negedge clock); endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wr(logic [7:0] d);
        transmit_data_reg = d;
        pulse(transmit_data_reg_wr);
    endtask
    // Edges are counted from after the write, past any idle level change
    task automatic frame(logic [7:0] d, int exp);
        wr(d);
        edges = 0;
        for (int k = 0; k < 400 && rx_full_flag !== 1'b1; k++) tick(1);
        tick(4);
        `CHK(edges, exp)
        `CHK(rx_data, d)
        pulse(rx_read);
    endtask
    task automatic t_stop;
        wr(8'ha5);
        pulse(enable_cmd);
        frame(8'h3c, 16);
        frame(8'hc3, 16);
        tick(2);
        pulse(disable_cmd);
        wr(8'h71);
        `CHK(tx_wr_ready, 1'b1)
        tick(1);
        wr(8'h72);
        `CHK(tx_holding_empty_flag, 1'b1)
        pulse(enable_cmd);
        tick(40);
        `CHK(busy, 1'b0)
    endtask
    task automatic t_fill;
        int i;
        for (i = 0; i < 12 && tx_wr_ready === 1'b1; i++) begin
            wr(8'(8'h10 + i));
            tick(1);
        end
        `CHK(tx_wr_ready, 1'b0)
        // Disable with a full queue: ready must come back and swallow
        pulse(disable_cmd);
        wr(8'h7f);
        `CHK(tx_wr_ready, 1'b1)
        `CHK(tx_holding_empty_flag, 1'b0)
        pulse(enable_cmd);
        for (int k = 0; k < i; k++) begin
            for (int j = 0; j < 400 && rx_full_flag !== 1'b1; j++) tick(1);
            `CHK(rx_data, 8'(8'h10 + k))
            pulse(rx_read);
        end
    endtask
    task automatic t_quirk;
        cs_in_use = 4'h3;
        clock_polarity = 4'h3;
        phase_capture_select = 4'h0;
        baud_divider_field = 32'h04040102;
        frame(8'h96, 16);
        cs_select = 2'h1;
        frame(8'h69, 18);
    endtask
    task automatic t_slave;
        master_mode = 1'b0;
        pulse(disable_cmd);
        `CHK(spi_enabled, 1'b1)
        pulse(rx_read);
        pulse(soft_reset_bit);
        `CHK(spi_enabled, 1'b0)
        `CHK(cs_n, 4'hf)
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        tick(8);
        rst_n = 1'b1;
        t_stop;
        t_fill;
        t_quirk;
        t_slave;
        wrap_up;
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
